/* File: include/scti_pkg.sv */
/*
  scti_pkg: register offsets, field positions, reset values and timing constants
  for the measurement-cycle timing and threshold-interrupt block.
  assumes a 50 MHz system clock.
*/
package scti_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] ADDR_ENABLE = 8'h80;
  localparam logic [7:0] ADDR_PROX_PERIOD = 8'h82;
  localparam logic [7:0] ADDR_IDLE = 8'h83;
  localparam logic [7:0] ADDR_LLL = 8'h84;
  localparam logic [7:0] ADDR_LLH = 8'h85;
  localparam logic [7:0] ADDR_LHL = 8'h86;
  localparam logic [7:0] ADDR_LHH = 8'h87;
  localparam logic [7:0] ADDR_PLL = 8'h88;
  localparam logic [7:0] ADDR_PLH = 8'h89;
  localparam logic [7:0] ADDR_PHL = 8'h8a;
  localparam logic [7:0] ADDR_PHH = 8'h8b;
  localparam logic [7:0] ADDR_FILTER = 8'h8c;
  localparam logic [7:0] ADDR_CONFIG = 8'h8d;
  localparam logic [7:0] ADDR_STATUS = 8'h93;
  // ==========================================
  // field positions
  localparam int BIT_POWER = 0;
  localparam int BIT_LIGHT_EN = 1;
  localparam int BIT_PROX_EN = 2;
  localparam int BIT_IDLE_EN = 3;
  localparam int BIT_LIGHT_IRQ_EN = 4;
  localparam int BIT_PROX_IRQ_EN = 5;
  localparam int BIT_LONG_IDLE = 2;
  localparam int BIT_ST_LIGHT = 4;
  localparam int BIT_ST_PROX = 5;
  localparam logic [7:0] ENABLE_MASK = 8'h3f;
  localparam logic [7:0] CONFIG_MASK = 8'h24;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_PROX_PERIOD = 8'h00;
  localparam logic [7:0] RST_IDLE = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_TIME_NS = 2780000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LONG_FACTOR = 4'hc;
  localparam logic [8:0] IDLE_BASE = 9'h100;
  localparam logic [5:0] LIGHT_FILT_KNEE = 6'h03;
  localparam logic [5:0] LIGHT_FILT_STEP = 6'h05;
  // ==========================================
  // light-cycle states
  typedef enum logic [1:0] {
    LS_OFF = 2'b00,
    LS_MEASURE = 2'b01,
    LS_IDLE = 2'b10
  } scti_light_e;
endpackage : scti_pkg

/* File: include/scti_filt_if.sv */
/*
  scti_filt_if: carries one threshold channel into a persistence filter.
  assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface scti_filt_if;
  logic sample;
  logic out_of_range;
  logic [5:0] need;
  logic fire;
  modport filt (input sample, input out_of_range, input need, output fire);
  modport user (output sample, output out_of_range, output need, input fire);
endinterface : scti_filt_if
`default_nettype wire

/* File: core/scti_persist.sv */
/*
  scti_persist: counts consecutive out-of-range samples and fires once the count
  reaches the needed number; a need of zero fires on every sample.
  assumes sample is a one-cycle strobe on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module scti_persist (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  scti_filt_if.filt f
);
  // ==========================================
  // consecutive counter
  logic [5:0] run_r;
  logic [6:0] run_inc;
  assign run_inc = {1'b0, run_r} + 7'h01;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      run_r <= 6'h00;
    end else if (f.sample) begin
      if (!f.out_of_range) begin
        run_r <= 6'h00;
      end else if (run_r != 6'h3f) begin
        run_r <= run_inc[5:0];
      end
    end
  end

  // ==========================================
  // fire pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      f.fire <= 1'b0;
    end else begin
      // zero means every sample, in range or not
      f.fire <= f.sample && ((f.need == 6'h00) ||
                (f.out_of_range && (run_inc >= {1'b0, f.need})));
    end
  end
endmodule : scti_persist
`default_nettype wire

/* File: core/scti_core.sv */
/*
  scti_core: proximity sample timer, light-cycle idle timer, threshold registers
  and persistence-filtered interrupt for an optical sensor.
  assumes the front end answers start pulses with result strobes on the system
  clock, and that the serial-bus slave drives the plain register port.
*/
// How it works
// - proximity period is one step times register value plus one
// - proximity period register resets to zero
// - one proximity start pulse per elapsed sample period
// - idle gap between light cycles is 256 minus register steps
// - long scale makes each idle step twelve base steps
// - idle register resets to all ones
// - light limits compare against the clear channel count only
// - clear count outside limits for filter count raises interrupt
// - light limit bytes sit at 0x84 to 0x87
// - proximity result below low or above high limit qualifies
// - proximity events pass the proximity persistence filter
// - proximity limit bytes sit at 0x88 to 0x8b
// - count consecutive out-of-range samples, in-range clears, up to 63
// - light filter decodes 0..3 directly, above that five times value minus three
// - each interrupt kind only while its enable bit is set
// - long scale bit is bit 2 of config register 0x8d
`timescale 1ns/1ps
`default_nettype none
module scti_core #(
  parameter int STEP_CYC = scti_pkg::STEP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [15:0] i_prox_result,
  input wire logic i_prox_valid,
  input wire logic [15:0] i_clear_channel_count,
  input wire logic i_light_valid,
  output logic o_prox_start,
  output logic o_light_start,
  output logic o_irq_n
);
  import scti_pkg::*;

  // refused at elaboration: the divider needs at least two cycles per step
  if (STEP_CYC < 2) begin : g_bad_step
    $error("scti_core: STEP_CYC must be at least 2");
  end

  // ==========================================
  // register file
  logic [7:0] enable_r;
  logic [7:0] prox_sample_period_r;
  logic [7:0] idle_interval_r;
  logic [7:0] light_low_limit_lo_r;
  logic [7:0] light_low_limit_hi_r;
  logic [7:0] light_high_limit_lo_r;
  logic [7:0] light_high_limit_hi_r;
  logic [7:0] prox_low_limit_lo_r;
  logic [7:0] prox_low_limit_hi_r;
  logic [7:0] prox_high_limit_lo_r;
  logic [7:0] prox_high_limit_hi_r;
  logic [7:0] filter_r;
  logic [7:0] config_r;
  logic light_flag_r;
  logic prox_flag_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      enable_r <= RST_ZERO;
      prox_sample_period_r <= RST_PROX_PERIOD;
      idle_interval_r <= RST_IDLE;
      light_low_limit_lo_r <= RST_ZERO;
      light_low_limit_hi_r <= RST_ZERO;
      light_high_limit_lo_r <= RST_ZERO;
      light_high_limit_hi_r <= RST_ZERO;
      prox_low_limit_lo_r <= RST_ZERO;
      prox_low_limit_hi_r <= RST_ZERO;
      prox_high_limit_lo_r <= RST_ZERO;
      prox_high_limit_hi_r <= RST_ZERO;
      filter_r <= RST_ZERO;
      config_r <= RST_ZERO;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_ENABLE: enable_r <= i_reg_wdata & ENABLE_MASK;
        ADDR_PROX_PERIOD: prox_sample_period_r <= i_reg_wdata;
        ADDR_IDLE: idle_interval_r <= i_reg_wdata;
        ADDR_LLL: light_low_limit_lo_r <= i_reg_wdata;
        ADDR_LLH: light_low_limit_hi_r <= i_reg_wdata;
        ADDR_LHL: light_high_limit_lo_r <= i_reg_wdata;
        ADDR_LHH: light_high_limit_hi_r <= i_reg_wdata;
        ADDR_PLL: prox_low_limit_lo_r <= i_reg_wdata;
        ADDR_PLH: prox_low_limit_hi_r <= i_reg_wdata;
        ADDR_PHL: prox_high_limit_lo_r <= i_reg_wdata;
        ADDR_PHH: prox_high_limit_hi_r <= i_reg_wdata;
        ADDR_FILTER: filter_r <= i_reg_wdata;
        ADDR_CONFIG: config_r <= i_reg_wdata & CONFIG_MASK;
        default: begin
        end
      endcase
    end
  end

  logic power_on;
  logic long_idle_scale;
  assign power_on = enable_r[BIT_POWER];
  assign long_idle_scale = config_r[BIT_LONG_IDLE];

  // ==========================================
  // read port, registered
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_ENABLE: o_reg_rdata <= enable_r;
        ADDR_PROX_PERIOD: o_reg_rdata <= prox_sample_period_r;
        ADDR_IDLE: o_reg_rdata <= idle_interval_r;
        ADDR_LLL: o_reg_rdata <= light_low_limit_lo_r;
        ADDR_LLH: o_reg_rdata <= light_low_limit_hi_r;
        ADDR_LHL: o_reg_rdata <= light_high_limit_lo_r;
        ADDR_LHH: o_reg_rdata <= light_high_limit_hi_r;
        ADDR_PLL: o_reg_rdata <= prox_low_limit_lo_r;
        ADDR_PLH: o_reg_rdata <= prox_low_limit_hi_r;
        ADDR_PHL: o_reg_rdata <= prox_high_limit_lo_r;
        ADDR_PHH: o_reg_rdata <= prox_high_limit_hi_r;
        ADDR_FILTER: o_reg_rdata <= filter_r;
        ADDR_CONFIG: o_reg_rdata <= config_r;
        ADDR_STATUS: o_reg_rdata <= {2'b00, prox_flag_r, light_flag_r, 4'h0};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // base step divider
  // the divider runs only while powered, so a period starts clean at power-up
  logic [31:0] div_r;
  logic step_tick;
  assign step_tick = power_on && (div_r == 32'(STEP_CYC - 1));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !power_on || step_tick) begin
      div_r <= 32'h0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // ==========================================
  // proximity sample timer
  logic [7:0] prox_steps_r;
  logic prox_run;
  assign prox_run = power_on && enable_r[BIT_PROX_EN];

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !prox_run) begin
      prox_steps_r <= 8'h00;
      o_prox_start <= 1'b0;
    end else begin
      o_prox_start <= 1'b0;
      if (step_tick) begin
        if (prox_steps_r == prox_sample_period_r) begin
          prox_steps_r <= 8'h00;
          o_prox_start <= 1'b1;
        end else begin
          prox_steps_r <= prox_steps_r + 8'h01;
        end
      end
    end
  end

  // ==========================================
  // light cycle with idle gap
  scti_light_e light_state_r;
  logic [8:0] idle_left_r;
  logic [3:0] long_sub_r;
  logic light_run;
  logic idle_step;
  assign light_run = power_on && enable_r[BIT_LIGHT_EN];
  // idle length is read when the gap opens
  assign idle_step = step_tick && (!long_idle_scale || (long_sub_r == LONG_FACTOR - 4'h1));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !light_run) begin
      light_state_r <= LS_OFF;
      idle_left_r <= 9'h000;
      long_sub_r <= 4'h0;
      o_light_start <= 1'b0;
    end else begin
      o_light_start <= 1'b0;
      case (light_state_r)
        LS_OFF: begin
          light_state_r <= LS_MEASURE;
          o_light_start <= 1'b1;
        end
        LS_MEASURE: begin
          if (i_light_valid) begin
            if (enable_r[BIT_IDLE_EN]) begin
              light_state_r <= LS_IDLE;
              idle_left_r <= IDLE_BASE - {1'b0, idle_interval_r};
              long_sub_r <= 4'h0;
            end else begin
              o_light_start <= 1'b1;
            end
          end
        end
        LS_IDLE: begin
          if (step_tick) begin
            long_sub_r <= (idle_step || !long_idle_scale) ? 4'h0 : long_sub_r + 4'h1;
          end
          if (idle_step) begin
            if (idle_left_r == 9'h001) begin
              light_state_r <= LS_MEASURE;
              o_light_start <= 1'b1;
            end
            idle_left_r <= idle_left_r - 9'h001;
          end
        end
        default: light_state_r <= LS_OFF;
      endcase
    end
  end

  // ==========================================
  // threshold compare
  logic [15:0] light_low_limit;
  logic [15:0] light_high_limit;
  logic [15:0] prox_low_limit;
  logic [15:0] prox_high_limit;
  assign light_low_limit = {light_low_limit_hi_r, light_low_limit_lo_r};
  assign light_high_limit = {light_high_limit_hi_r, light_high_limit_lo_r};
  assign prox_low_limit = {prox_low_limit_hi_r, prox_low_limit_lo_r};
  assign prox_high_limit = {prox_high_limit_hi_r, prox_high_limit_lo_r};

  logic [3:0] lf;
  logic [5:0] lf_wide;
  logic [5:0] light_need;
  logic [5:0] light_mul;
  assign lf = filter_r[3:0];
  assign lf_wide = {2'b00, lf};
  assign light_mul = 6'((lf_wide - LIGHT_FILT_KNEE) * LIGHT_FILT_STEP);
  assign light_need = (lf_wide <= LIGHT_FILT_KNEE) ? lf_wide : light_mul;

  scti_filt_if light_if ();
  scti_filt_if prox_if ();

  assign light_if.sample = i_light_valid && light_run;
  assign light_if.out_of_range = (i_clear_channel_count < light_low_limit) ||
                                 (i_clear_channel_count > light_high_limit);
  assign light_if.need = light_need;

  assign prox_if.sample = i_prox_valid && prox_run;
  assign prox_if.out_of_range = (i_prox_result < prox_low_limit) ||
                                (i_prox_result > prox_high_limit);
  assign prox_if.need = {2'b00, filter_r[7:4]};

  scti_persist u_light_persist (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .f(light_if.filt)
  );

  scti_persist u_prox_persist (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .f(prox_if.filt)
  );

  // ==========================================
  // sticky flags and pin
  // write one to clear; a fire in the same cycle keeps the flag set
  logic clr_wr;
  assign clr_wr = i_reg_wr && (i_reg_addr == ADDR_STATUS);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      light_flag_r <= 1'b0;
      prox_flag_r <= 1'b0;
    end else begin
      if (light_if.fire && enable_r[BIT_LIGHT_IRQ_EN]) begin
        light_flag_r <= 1'b1;
      end else if (clr_wr && i_reg_wdata[BIT_ST_LIGHT]) begin
        light_flag_r <= 1'b0;
      end
      if (prox_if.fire && enable_r[BIT_PROX_IRQ_EN]) begin
        prox_flag_r <= 1'b1;
      end else if (clr_wr && i_reg_wdata[BIT_ST_PROX]) begin
        prox_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= !((light_flag_r && enable_r[BIT_LIGHT_IRQ_EN]) ||
                   (prox_flag_r && enable_r[BIT_PROX_IRQ_EN]));
    end
  end
endmodule : scti_core
`default_nettype wire

/* File: sim/scti_core_props.sv */
/* scti_core_props: port assertions for scti_core.
   assumes a bind to scti_core and a sync active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module scti_core_props #(parameter int STEP_CYC = 4) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [15:0] i_prox_result,
  input wire logic i_prox_valid,
  input wire logic [15:0] i_clear_channel_count,
  input wire logic i_light_valid,
  input wire logic o_prox_start,
  input wire logic o_light_start,
  input wire logic o_irq_n
);
  // ==========================================
  // shadow of enable and period
  logic [7:0] en_r;
  logic [7:0] per_r;
  logic [31:0] cnt_r;
  logic armed_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      en_r <= 8'h00;
      per_r <= 8'h00;
    end else if (i_reg_wr && i_reg_addr == 8'h80) begin
      en_r <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == 8'h82) begin
      per_r <= i_reg_wdata;
    end
  end
  // any write disarms: the divider may re-phase
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || i_reg_wr) begin
      cnt_r <= 32'h0;
      armed_r <= 1'b0;
    end else if (o_prox_start) begin
      cnt_r <= 32'h1;
      armed_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  chk_prox_spacing: assert property (o_prox_start && armed_r |-> cnt_r == STEP_CYC * (per_r + 1))
    else $error("prox start spacing wrong");
  chk_prox_pulse: assert property (o_prox_start |=> !o_prox_start)
    else $error("prox start longer than one cycle");
  chk_limit_back: assert property (i_reg_wr && i_reg_addr inside {[8'h84:8'h8b]} ##1 !i_reg_wr
    ##1 i_reg_rd && i_reg_addr == $past(i_reg_addr, 2) |=> o_reg_rdata == $past(i_reg_wdata, 3))
    else $error("limit byte readback wrong");
  chk_irq_cause: assert property ($fell(o_irq_n) |-> $past(i_prox_valid, 3) || $past(i_light_valid, 3)
    || $past(i_reg_wr) || $past(i_reg_wr, 2))
    else $error("irq without a sample");
  chk_irq_gated: assert property (!o_irq_n |-> ((en_r | $past(en_r)) & 8'h30) != 8'h00)
    else $error("irq while disabled");
  chk_irq_drop: assert property (i_reg_wr && i_reg_addr == 8'h80 && i_reg_wdata[5:4] == 2'b00
    |-> ##[1:2] o_irq_n)
    else $error("irq stays after disable");
  chk_light_next: assert property (i_light_valid && en_r[3:0] == 4'h3 |-> ##[1:2] o_light_start)
    else $error("no restart without idle");
  chk_idle_hold: assert property (i_light_valid && en_r[3:0] == 4'hb |=> !o_light_start)
    else $error("restart skipped idle gap");
  cover property (o_prox_start && armed_r);
  cover property (!o_irq_n ##1 o_irq_n);
  cover property (i_light_valid && en_r[3]);
endmodule : scti_core_props
bind scti_core scti_core_props #(.STEP_CYC(STEP_CYC)) u_props (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_prox_result(i_prox_result), .i_prox_valid(i_prox_valid),
  .i_clear_channel_count(i_clear_channel_count), .i_light_valid(i_light_valid),
  .o_prox_start(o_prox_start), .o_light_start(o_light_start), .o_irq_n(o_irq_n));
`default_nettype wire

/* File: sim/scti_fe_model.sv */
/* scti_fe_model: front end answering start pulses with result strobes.
   assumes the system clock; latency set by the bench. */
`timescale 1ns/1ps
`default_nettype none
module scti_fe_model (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_lat,
  input wire logic i_prox_start,
  input wire logic i_light_start,
  input wire logic [15:0] i_prox_val,
  input wire logic [15:0] i_light_val,
  output logic [15:0] o_prox_result,
  output logic o_prox_valid,
  output logic [15:0] o_clear_count,
  output logic o_light_valid
);
  logic [4:0] pc_r;
  logic [4:0] lc_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) pc_r <= 5'h00;
    else if (i_prox_start) pc_r <= {1'b0, i_lat} + 5'h01;
    else if (pc_r != 5'h00) pc_r <= pc_r - 5'h01;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) lc_r <= 5'h00;
    else if (i_light_start) lc_r <= {1'b0, i_lat} + 5'h01;
    else if (lc_r != 5'h00) lc_r <= lc_r - 5'h01;
  end
  assign o_prox_valid = (pc_r == 5'h01);
  assign o_light_valid = (lc_r == 5'h01);
  // junk outside the strobe so a late sample shows
  assign o_prox_result = o_prox_valid ? i_prox_val : ~i_prox_val;
  assign o_clear_count = o_light_valid ? i_light_val : ~i_light_val;
endmodule : scti_fe_model
`default_nettype wire

/* File: sim/scti_core_tb.sv */
/* scti_core_tb: register, timing and interrupt tests for scti_core.
   assumes scti_fe_model as front end and a four-cycle step. */
`timescale 1ns/1ps
`default_nettype none
module scti_core_tb;
  localparam int STEP = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, d;
  logic [15:0] presult, ccount;
  logic pvalid, lvalid, pstart, lstart, irq_n;
  logic [15:0] pval = 16'h0150;
  logic [15:0] lval = 16'h0150;
  logic [3:0] lat = 4'h2;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int pv_cnt = 0;
  int lv_cnt = 0;
  int n, t, lo;
  int pp [3] = '{0, 3, 255};
  int fv [5] = '{0, 1, 3, 4, 15};
  int fn [5] = '{1, 2, 4, 6, 61};
  scti_core #(.STEP_CYC(STEP)) uut (.i_sys_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_prox_result(presult), .i_prox_valid(pvalid),
    .i_clear_channel_count(ccount), .i_light_valid(lvalid), .o_prox_start(pstart), .o_light_start(lstart),
    .o_irq_n(irq_n));
  scti_fe_model fe (.i_sys_clk(clk), .i_reset(rst), .i_lat(lat), .i_prox_start(pstart), .i_light_start(lstart),
    .i_prox_val(pval), .i_light_val(lval), .o_prox_result(presult), .o_prox_valid(pvalid),
    .o_clear_count(ccount), .o_light_valid(lvalid));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pv_cnt <= pv_cnt + int'(pvalid);
    lv_cnt <= lv_cnt + int'(lvalid);
  end
  // ==========================================
  // access and wait tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    v = rdata;
  endtask : rreg
  function automatic logic sel(input int w);
    case (w)
      0: return pstart;
      1: return lstart;
      2: return lvalid;
      default: return pvalid;
    endcase
  endfunction : sel
  // returns one edge after the pulse, so the sample has landed
  task automatic wait_for(input int w);
    int k;
    k = 0;
    while (sel(w) !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 3000) chk("wait", 1, 0);
    @(posedge clk);
    #1;
  endtask : wait_for
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq_n !== 1'b0 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 3000) chk("irq", 0, 1);
  endtask : wait_irq
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] watchdog exp done got timeout");
    complete_run;
  end
  // ==========================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    rreg(8'h82, d);
    chk("period rst", 8'h00, d);
    rreg(8'h83, d);
    chk("idle rst", 8'hff, d);
    for (int a = 8'h84; a <= 8'h8b; a++) begin
      wreg(8'(a), 8'(a) ^ 8'h5a);
      rreg(8'(a), d);
      chk("limit byte", 8'(a) ^ 8'h5a, d);
    end
    for (int i = 0; i < 2; i++) begin
      wreg(8'h84 + 8'(4 * i), 8'h00);
      wreg(8'h85 + 8'(4 * i), 8'h01);
      wreg(8'h86 + 8'(4 * i), 8'h00);
      wreg(8'h87 + 8'(4 * i), (i == 0) ? 8'hff : 8'h02);
    end
    foreach (pp[i]) begin
      wreg(8'h82, 8'(pp[i]));
      wreg(8'h80, 8'h05);
      wait_for(0);
      t = cyc;
      wait_for(0);
      chk("prox period", STEP * (pp[i] + 1), cyc - t);
      wreg(8'h80, 8'h00);
    end
    lat = 4'h4;
    foreach (fv[i]) begin
      wreg(8'h8c, 8'(fv[i]));
      lval = 16'h9000;
      n = lv_cnt;
      wreg(8'h80, 8'h13);
      wait_for(2);
      lval = 16'hff80;
      wait_irq;
      chk("light need", fn[i], lv_cnt - n);
      wreg(8'h80, 8'h00);
      wreg(8'h93, 8'h30);
      repeat (8) @(posedge clk);
    end
    wreg(8'h82, 8'h03);
    wreg(8'h8c, 8'h20);
    pval = 16'h0050;
    wreg(8'h80, 8'h05);
    repeat (3) wait_for(3);
    chk("irq masked", 1, irq_n);
    wreg(8'h80, 8'h25);
    n = pv_cnt;
    wait_irq;
    chk("prox refire", 1, pv_cnt - n);
    pval = 16'h0150;
    wait_for(3);
    wreg(8'h93, 8'h30);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", 1, irq_n);
    pval = 16'h0250;
    n = pv_cnt;
    wait_irq;
    chk("prox need", 2, pv_cnt - n);
    rreg(8'h93, d);
    chk("status", 8'h20, d);
    wreg(8'h80, 8'h05);
    @(posedge clk);
    #1;
    chk("irq off", 1, irq_n);
    wreg(8'h80, 8'h00);
    for (int lg = 0; lg < 2; lg++) begin
      wreg(8'h8d, lg ? 8'hff : 8'h00);
      rreg(8'h8d, d);
      chk("config", lg ? 8'h24 : 8'h00, d);
      wreg(8'h83, 8'hfd);
      wreg(8'h80, 8'h0b);
      wait_for(2);
      t = cyc;
      wait_for(1);
      lo = 3 * STEP * (lg ? 12 : 1);
      chk("idle gap", 1, (cyc - t >= lo - STEP) && (cyc - t <= lo + STEP));
      wreg(8'h80, 8'h00);
    end
    complete_run;
  end
endmodule : scti_core_tb
`default_nettype wire
